// ### common/aspf_pkg.sv
// Constants, types and shared functions of the asynchronous serial port.
// Assumes one clock; all users refer to items as aspf_pkg::name.
// Behaviour
// - Bit rate is clock over (65536 minus reload), then over 2, then over prescale.
// - Frame: low start, data LSB first, optional parity or extra bit, high stops.
// - Character length is selectable from five to eight data bits.
// - Parity, when enabled, is generated on transmit and checked on receive.
// - One or two stop bits; the second only for six to eight data bits.
// - Parity takes the bit after the data; extra bit is then unavailable.
// - Transmit and receive run at once and independently on their own pins.
// - Data write to an empty holding register loads it and clears the holding-empty flag.
// - Transmit-done flag sets at the start of the first stop bit of every frame.
// - Extra bit without parity sends the transmit-extra-bit control value.
// - Parity bit follows the selected parity type and comes after the data.
// - Frames are accepted only after receive enable has been set.
// - After the stop bit, a good byte enters the three-deep receive FIFO.
// - A byte completing while the FIFO is full is lost and sets overrun.
// - A byte with any low stop bit is not placed into the FIFO.
package aspf_pkg;
   localparam logic [11:0] ADDR_DATA = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;
   localparam logic [11:0] ADDR_FMT = 12'h008;
   localparam logic [11:0] ADDR_BAUD = 12'h00C;
   localparam int CTRL_RDY = 0;
   localparam int CTRL_TDONE = 1;
   localparam int CTRL_THRE = 2;
   localparam int CTRL_TBX = 3;
   localparam int CTRL_REN = 4;
   localparam int CTRL_OVR = 5;
   localparam int CTRL_RBX = 6;
   localparam int CTRL_PERR = 7;
   localparam int CTRL_FERR = 8;
   localparam int FMT_LEN = 0;
   localparam int FMT_XBE = 2;
   localparam int FMT_PE = 3;
   localparam int FMT_PT = 4;
   localparam int FMT_STOP2 = 6;
   localparam int FMT_MCE = 7;
   localparam int BAUD_PS = 16;
   localparam logic [7:0] FMT_RESET = 8'h03;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [1:0] PS_RESET = 2'h0;
   localparam logic [15:0] BAUD_WRAP = 16'hFFFF;
   localparam logic [5:0] PS_DIV0 = 6'h0C;
   localparam logic [5:0] PS_DIV1 = 6'h04;
   localparam logic [5:0] PS_DIV2 = 6'h30;
   localparam logic [5:0] PS_DIV3 = 6'h01;
   localparam logic [1:0] PT_ODD = 2'h0;
   localparam logic [1:0] PT_EVEN = 2'h1;
   localparam logic [1:0] PT_MARK = 2'h2;
   localparam logic [1:0] PT_SPACE = 2'h3;
   localparam logic [1:0] RX_DEPTH = 2'h3;
   typedef struct packed {
      logic [15:0] reload;
      logic [1:0] len;
      logic xbe;
      logic pe;
      logic [1:0] pt;
      logic stop2;
      logic mce;
      logic tbx;
      logic ren;
   } aspf_cfg_t;
   typedef struct packed {
      logic [7:0] data;
      logic xbit;
   } aspf_rx_word_t;
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len, input logic [1:0] pt);
      logic x;
      x = ^(d & (8'hFF >> (2'h3 - len)));
      case (pt)
         PT_ODD: par_bit = ~x;
         PT_EVEN: par_bit = x;
         PT_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction
   function automatic logic stop2_ok(input aspf_cfg_t c);
      stop2_ok = c.stop2 && (c.len != 2'h0);
   endfunction
   function automatic logic xbit_used(input aspf_cfg_t c);
      xbit_used = c.pe || c.xbe;
   endfunction
endpackage

// ### src/aspf_tx.sv
// Transmit shifter of the serial port.
// Assumes tick is a one-cycle prescaler pulse and go is held until taken.
`timescale 1ns/10ps
module aspf_tx (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire aspf_pkg::aspf_cfg_t cfg,
   input wire logic go,
   input wire logic [7:0] data,
   output logic taken,
   output logic done,
   output logic pin
);
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100, TX_EXTRA = 5'b01000, TX_STOP = 5'b10000
   } aspf_tx_state_t;
   aspf_tx_state_t state;
   logic [15:0] cnt;
   logic half;
   logic [7:0] shreg;
   logic [2:0] idx;
   logic extra;
   logic more_stop;
   logic bit_end;
   assign bit_end = tick && (cnt == aspf_pkg::BAUD_WRAP) && half;
   // Two reload wraps per bit give the final divide by two
   always_ff @(posedge clk) begin
      if (rst || state == TX_IDLE) begin
         cnt <= aspf_pkg::RELOAD_RESET;
         half <= 1'b0;
         if (!rst) cnt <= cfg.reload;
      end else if (tick) begin
         if (cnt == aspf_pkg::BAUD_WRAP) begin
            cnt <= cfg.reload;
            half <= ~half;
         end else begin
            cnt <= cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk) begin
      taken <= 1'b0;
      done <= 1'b0;
      if (rst) begin
         state <= TX_IDLE;
         pin <= 1'b1;
         shreg <= 8'h00;
         idx <= 3'h0;
         extra <= 1'b0;
         more_stop <= 1'b0;
      end else begin
         case (state)
            TX_IDLE: begin
               if (go) begin
                  taken <= 1'b1;
                  shreg <= data;
                  extra <= cfg.pe ? aspf_pkg::par_bit(data, cfg.len, cfg.pt) : cfg.tbx;
                  pin <= 1'b0;
                  state <= TX_START;
               end
            end
            TX_START: begin
               if (bit_end) begin
                  pin <= shreg[0];
                  shreg <= shreg >> 1;
                  idx <= 3'h0;
                  state <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (bit_end) begin
                  if (idx == {1'b0, cfg.len} + 3'h4) begin
                     more_stop <= aspf_pkg::stop2_ok(cfg);
                     if (aspf_pkg::xbit_used(cfg)) begin
                        pin <= extra;
                        state <= TX_EXTRA;
                     end else begin
                        pin <= 1'b1;
                        done <= 1'b1;
                        state <= TX_STOP;
                     end
                  end else begin
                     pin <= shreg[0];
                     shreg <= shreg >> 1;
                     idx <= idx + 3'h1;
                  end
               end
            end
            TX_EXTRA: begin
               if (bit_end) begin
                  pin <= 1'b1;
                  done <= 1'b1;
                  state <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (bit_end) begin
                  if (more_stop) more_stop <= 1'b0;
                  else state <= TX_IDLE;
               end
            end
            default: begin
               pin <= 1'b1;
               state <= TX_IDLE;
            end
         endcase
      end
   end
endmodule // aspf_tx

// ### src/aspf_rx.sv
// Receive sampler of the serial port.
// Assumes the serial input is asynchronous; tick is a one-cycle prescaler pulse.
`timescale 1ns/10ps
module aspf_rx (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire aspf_pkg::aspf_cfg_t cfg,
   input wire logic pin,
   output logic done,
   output aspf_pkg::aspf_rx_word_t word,
   output logic stop_ok,
   output logic perr
);
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100, RX_EXTRA = 5'b01000, RX_STOP = 5'b10000
   } aspf_rx_state_t;
   aspf_rx_state_t state;
   logic s1, s2, s3, lvl, lvl_d;
   logic [15:0] cnt;
   logic half;
   logic [7:0] shreg;
   logic [2:0] idx;
   logic more_stop;
   logic sample;
   // A level change counts only once the last two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         lvl <= 1'b1;
         lvl_d <= 1'b1;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) lvl <= s3;
         lvl_d <= lvl;
      end
   end
   // First wrap lands mid start bit; later samples come every second wrap
   assign sample = tick && (cnt == aspf_pkg::BAUD_WRAP) && !half;
   always_ff @(posedge clk) begin
      if (rst || state == RX_IDLE) begin
         cnt <= aspf_pkg::RELOAD_RESET;
         half <= 1'b0;
         if (!rst) cnt <= cfg.reload;
      end else if (tick) begin
         if (cnt == aspf_pkg::BAUD_WRAP) begin
            cnt <= cfg.reload;
            half <= ~half;
         end else begin
            cnt <= cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         state <= RX_IDLE;
         shreg <= 8'h00;
         idx <= 3'h0;
         more_stop <= 1'b0;
         word <= '0;
         stop_ok <= 1'b0;
         perr <= 1'b0;
      end else begin
         case (state)
            RX_IDLE: begin
               if (cfg.ren && lvl_d && !lvl) state <= RX_START;
            end
            RX_START: begin
               if (sample) begin
                  idx <= 3'h0;
                  shreg <= 8'h00;
                  state <= lvl ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (sample) begin
                  shreg <= {lvl, shreg[7:1]};
                  idx <= idx + 3'h1;
                  if (idx == {1'b0, cfg.len} + 3'h4) begin
                     stop_ok <= 1'b1;
                     perr <= 1'b0;
                     word.xbit <= 1'b0;
                     more_stop <= aspf_pkg::stop2_ok(cfg);
                     state <= aspf_pkg::xbit_used(cfg) ? RX_EXTRA : RX_STOP;
                  end
               end
            end
            RX_EXTRA: begin
               if (sample) begin
                  word.xbit <= lvl;
                  if (cfg.pe) perr <= lvl != aspf_pkg::par_bit(word.data, cfg.len, cfg.pt);
                  state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (sample) begin
                  if (!lvl) stop_ok <= 1'b0;
                  if (more_stop) begin
                     more_stop <= 1'b0;
                  end else begin
                     done <= 1'b1;
                     state <= RX_IDLE;
                  end
               end
            end
            default: state <= RX_IDLE;
         endcase
         if (state == RX_DATA && sample && idx == {1'b0, cfg.len} + 3'h4) begin
            word.data <= {lvl, shreg[7:1]} >> (2'h3 - cfg.len);
         end
      end
   end
endmodule // aspf_rx

// ### src/aspf_top.sv
// Serial port top: APB register slave, prescaler, holding register, receive FIFO.
// Assumes an APB master on SYS_CLK and pins already synchronised nowhere.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module aspf_top (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_OUT_PIN
);
   aspf_pkg::aspf_cfg_t cfg;
   logic [5:0] ps_cnt;
   logic pre_tick;
   logic [7:0] hold;
   logic hold_empty;
   logic tx_taken, tx_done, tx_pin;
   logic rx_done, rx_stop_ok, rx_perr;
   aspf_pkg::aspf_rx_word_t rx_word;
   aspf_pkg::aspf_rx_word_t fifo_mem [0:2];
   logic [1:0] wr_ptr, rd_ptr, fifo_cnt;
   logic tdone, ovr, perr_f, ferr;
   logic acc, wr_acc, rd_acc, mapped;
   logic push, pop, rx_accept, fifo_full;
   logic [31:0] next_rdata;

   function automatic logic [5:0] ps_div(input logic [1:0] sel);
      case (sel)
         2'h0: ps_div = aspf_pkg::PS_DIV0;
         2'h1: ps_div = aspf_pkg::PS_DIV1;
         2'h2: ps_div = aspf_pkg::PS_DIV2;
         default: ps_div = aspf_pkg::PS_DIV3;
      endcase
   endfunction

   function automatic logic [1:0] ptr_inc(input logic [1:0] p);
      ptr_inc = (p == aspf_pkg::RX_DEPTH - 2'h1) ? 2'h0 : p + 2'h1;
   endfunction

   logic [1:0] ps_sel;

   // Access phase with PREADY high is the one edge at which anything takes effect
   assign acc = PSEL && PENABLE && PREADY;
   assign wr_acc = acc && PWRITE;
   assign rd_acc = acc && !PWRITE;
   assign mapped = (PADDR == aspf_pkg::ADDR_DATA) || (PADDR == aspf_pkg::ADDR_CTRL) ||
                   (PADDR == aspf_pkg::ADDR_FMT) || (PADDR == aspf_pkg::ADDR_BAUD);

   // Prescaler: one tick every selected number of clocks
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ps_cnt <= 6'h00;
         pre_tick <= 1'b0;
      end else if (ps_cnt >= ps_div(ps_sel) - 6'h01) begin
         ps_cnt <= 6'h00;
         pre_tick <= 1'b1;
      end else begin
         ps_cnt <= ps_cnt + 6'h01;
         pre_tick <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cfg.reload <= aspf_pkg::RELOAD_RESET;
         ps_sel <= aspf_pkg::PS_RESET;
         {cfg.mce, cfg.stop2, cfg.pt, cfg.pe, cfg.xbe, cfg.len} <= aspf_pkg::FMT_RESET;
         cfg.tbx <= 1'b0;
         cfg.ren <= 1'b0;
      end else if (wr_acc) begin
         case (PADDR)
            aspf_pkg::ADDR_FMT: begin
               cfg.len <= PWDATA[aspf_pkg::FMT_LEN +: 2];
               cfg.xbe <= PWDATA[aspf_pkg::FMT_XBE];
               cfg.pe <= PWDATA[aspf_pkg::FMT_PE];
               cfg.pt <= PWDATA[aspf_pkg::FMT_PT +: 2];
               cfg.stop2 <= PWDATA[aspf_pkg::FMT_STOP2];
               cfg.mce <= PWDATA[aspf_pkg::FMT_MCE];
            end
            aspf_pkg::ADDR_BAUD: begin
               cfg.reload <= PWDATA[15:0];
               ps_sel <= PWDATA[aspf_pkg::BAUD_PS +: 2];
            end
            aspf_pkg::ADDR_CTRL: begin
               cfg.tbx <= PWDATA[aspf_pkg::CTRL_TBX];
               cfg.ren <= PWDATA[aspf_pkg::CTRL_REN];
            end
            default: begin
            end
         endcase
      end
   end

   // Holding register; a write while full is dropped and the held byte kept
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         hold <= 8'h00;
         hold_empty <= 1'b1;
      end else if (wr_acc && PADDR == aspf_pkg::ADDR_DATA && hold_empty) begin
         hold <= PWDATA[7:0];
         hold_empty <= 1'b0;
      end else if (tx_taken) begin
         hold_empty <= 1'b1;
      end
   end

   aspf_tx u_tx (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .tick(pre_tick),
      .cfg(cfg),
      .go(!hold_empty),
      .data(hold),
      .taken(tx_taken),
      .done(tx_done),
      .pin(tx_pin)
   );

   aspf_rx u_rx (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .tick(pre_tick),
      .cfg(cfg),
      .pin(SERIAL_IN_PIN),
      .done(rx_done),
      .word(rx_word),
      .stop_ok(rx_stop_ok),
      .perr(rx_perr)
   );

   // Both shifters share only the prescaler tick and the configuration, so they run independently
   assign SERIAL_OUT_PIN = tx_pin;

   // In multidrop mode with the extra bit enabled and parity off, only frames with the extra bit set are kept
   assign rx_accept = !(cfg.mce && cfg.xbe && !cfg.pe) || rx_word.xbit;
   assign fifo_full = fifo_cnt == aspf_pkg::RX_DEPTH;
   // Full is judged before a same-cycle pop, so a read cannot rescue the byte
   assign push = rx_done && rx_stop_ok && rx_accept && !fifo_full;
   assign pop = rd_acc && PADDR == aspf_pkg::ADDR_DATA && fifo_cnt != 2'h0;

   always_ff @(posedge SYS_CLK) begin
      if (push) fifo_mem[wr_ptr] <= rx_word;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
         fifo_cnt <= 2'h0;
      end else begin
         if (push) wr_ptr <= ptr_inc(wr_ptr);
         if (pop) rd_ptr <= ptr_inc(rd_ptr);
         if (push && !pop) fifo_cnt <= fifo_cnt + 2'h1;
         else if (pop && !push) fifo_cnt <= fifo_cnt - 2'h1;
      end
   end

   // Sticky flags: write one to clear, a new event in the same cycle wins
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         tdone <= 1'b0;
         ovr <= 1'b0;
         perr_f <= 1'b0;
         ferr <= 1'b0;
      end else begin
         if (wr_acc && PADDR == aspf_pkg::ADDR_CTRL) begin
            if (PWDATA[aspf_pkg::CTRL_TDONE]) tdone <= 1'b0;
            if (PWDATA[aspf_pkg::CTRL_OVR]) ovr <= 1'b0;
            if (PWDATA[aspf_pkg::CTRL_PERR]) perr_f <= 1'b0;
            if (PWDATA[aspf_pkg::CTRL_FERR]) ferr <= 1'b0;
         end
         if (tx_done) tdone <= 1'b1;
         if (rx_done && rx_stop_ok && rx_accept && fifo_full) ovr <= 1'b1;
         if (rx_done && rx_perr && cfg.pe) perr_f <= 1'b1;
         if (rx_done && !rx_stop_ok) ferr <= 1'b1;
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (PADDR)
         aspf_pkg::ADDR_DATA: begin
            if (fifo_cnt != 2'h0) next_rdata[7:0] = fifo_mem[rd_ptr].data;
         end
         aspf_pkg::ADDR_CTRL: begin
            next_rdata[aspf_pkg::CTRL_RDY] = fifo_cnt != 2'h0;
            next_rdata[aspf_pkg::CTRL_TDONE] = tdone;
            next_rdata[aspf_pkg::CTRL_THRE] = hold_empty;
            next_rdata[aspf_pkg::CTRL_TBX] = cfg.tbx;
            next_rdata[aspf_pkg::CTRL_REN] = cfg.ren;
            next_rdata[aspf_pkg::CTRL_OVR] = ovr;
            next_rdata[aspf_pkg::CTRL_RBX] = (fifo_cnt != 2'h0) && fifo_mem[rd_ptr].xbit;
            next_rdata[aspf_pkg::CTRL_PERR] = perr_f;
            next_rdata[aspf_pkg::CTRL_FERR] = ferr;
         end
         aspf_pkg::ADDR_FMT: begin
            next_rdata[7:0] = {cfg.mce, cfg.stop2, cfg.pt, cfg.pe, cfg.xbe, cfg.len};
         end
         aspf_pkg::ADDR_BAUD: begin
            next_rdata[15:0] = cfg.reload;
            next_rdata[aspf_pkg::BAUD_PS +: 2] = ps_sel;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // No wait state: PREADY rises in the first access cycle, data captured in setup
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PREADY <= 1'b1;
         PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
         PSLVERR <= !mapped;
      end else begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end
endmodule // aspf_top

// ### testbench/aspf_assertions.sv
// Port checker of the serial port top: APB handshake, reset state, bit timing.
// Assumes a bind to aspf_top; the bit time is learnt from BAUD writes.
`timescale 1ns/10ps
module aspf_assertions (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic SERIAL_IN_PIN,
   input wire logic SERIAL_OUT_PIN
);
   logic [31:0] bit_clks;
   logic [31:0] run;
   logic [5:0] ps_div;
   logic mapped;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence access_s;
      PSEL && PENABLE && PREADY;
   endsequence
   assign mapped = PADDR[1:0] == 2'h0 && PADDR <= aspf_pkg::ADDR_BAUD;
   assign ps_div = PWDATA[17] ? (PWDATA[16] ? aspf_pkg::PS_DIV3 : aspf_pkg::PS_DIV2)
                              : (PWDATA[16] ? aspf_pkg::PS_DIV1 : aspf_pkg::PS_DIV0);
   // A baud change in mid-frame would confuse this model; the bench avoids it
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         bit_clks <= 32'h2 * (32'h10000 - {16'h0, aspf_pkg::RELOAD_RESET}) * {26'h0, aspf_pkg::PS_DIV0};
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == aspf_pkg::ADDR_BAUD) begin
         bit_clks <= 32'h2 * (32'h10000 - {16'h0, PWDATA[15:0]}) * {26'h0, ps_div};
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST || $changed(SERIAL_OUT_PIN)) begin
         run <= 32'h1;
      end else begin
         run <= run + 32'h1;
      end
   end
   chk_ready_after: assert property (setup_s |=> access_s) else $error("ready missing after setup");
   chk_ready_single: assert property (PREADY |=> !PREADY) else $error("ready held too long");
   chk_ready_cause: assert property (PREADY |-> $past(PSEL && !PENABLE)) else $error("ready without setup");
   chk_err_unmapped: assert property (setup_s ##0 !mapped |=> PSLVERR) else $error("no error on unmapped");
   chk_err_mapped: assert property (setup_s ##0 mapped |=> !PSLVERR) else $error("error on mapped");
   chk_err_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("data on error");
   chk_reset_quiet: assert property (disable iff (1'b0) SYS_RST |=> !PREADY && !PSLVERR && SERIAL_OUT_PIN
                                     && PRDATA == 32'h0) else $error("outputs not quiet in reset");
   chk_bit_width: assert property ($changed(SERIAL_OUT_PIN) |-> run >= bit_clks) else $error("bit too short");
endmodule // aspf_assertions

// ### testbench/aspf_peer.sv
// Far-side serial device: sends frames to the port and captures its output.
// Assumes a fixed bit time of BIT_CLKS system clocks; the line idles high.
`timescale 1ns/10ps
module aspf_peer #(parameter int BIT_CLKS = 4) (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // Start low, eight data bits LSB first, one stop bit (driven low for a fault)
   task automatic send(input logic [7:0] d, input logic stop_v);
      logic [9:0] f;
      f = {stop_v, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      line_out <= 1'b1;
      // Idle gap lets the receiver store the byte and raise its flags before the caller looks
      repeat (2 * BIT_CLKS) @(posedge clk);
   endtask
   // Samples mid-bit; hi counts high cycles from mid stop to the next start
   task automatic catch(input int nb, input bit hx, output logic [7:0] d, output logic x, output int hi,
                        output bit ok);
      int w;
      d = 8'h00;
      x = 1'b0;
      hi = 0;
      w = 0;
      while (line_in !== 1'b0 && w < 2000) begin
         @(posedge clk);
         w++;
      end
      ok = w < 2000;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         d[i] = line_in;
      end
      if (hx) begin
         repeat (BIT_CLKS) @(posedge clk);
         x = line_in;
      end
      repeat (BIT_CLKS) @(posedge clk);
      while (line_in === 1'b1 && hi < 40) begin
         @(posedge clk);
         hi++;
      end
   endtask
endmodule // aspf_peer

// ### testbench/aspf_top_test.sv
// Self-checking bench of the serial port top: APB tasks and a serial peer.
// Assumes reload 0xFFFE with prescale select 3, a bit time of 4 clocks.
`timescale 1ns/10ps
module aspf_top_test;
   localparam logic [7:0] FMTS [8] = '{8'h03, 8'h0B, 8'h1A, 8'h29, 8'h38, 8'hC7, 8'h44, 8'h0F};
   localparam logic [7:0] DATS [8] = '{8'hA5, 8'h37, 8'h55, 8'h2C, 8'h1F, 8'hC3, 8'h0A, 8'hFE};
   localparam logic [7:0] TBXS = 8'hA0;
   logic clk, rst, psel, pen, pwr, pready, pslverr, slverr, tx, rx, x, ex, p;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [7:0] d, f, m;
   int num_errors = 0;
   int checks_done = 0;
   int hi;
   aspf_top dut_u (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SERIAL_IN_PIN(rx),
      .SERIAL_OUT_PIN(tx));
   aspf_peer #(.BIT_CLKS(4)) peer_u (.clk(clk), .line_in(tx), .line_out(rx));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         cmp("pready", 32'h1, 32'h0);
         tally_and_finish();
      end
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic grab(input int nb, input bit hx);
      bit ok;
      peer_u.catch(nb, hx, d, x, hi, ok);
      if (!ok) begin
         cmp("frame start", 32'h1, 32'h0);
         tally_and_finish();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rst, psel, pen, pwr, paddr, pwdata} = {4'h8, 12'h000, 32'h0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(0, aspf_pkg::ADDR_CTRL, 0);
      cmp("ctrl reset", 32'h4, rdata);
      apb(0, aspf_pkg::ADDR_FMT, 0);
      cmp("format reset", {24'h0, aspf_pkg::FMT_RESET}, rdata);
      apb(0, 12'h010, 0);
      cmp("unmapped err", 32'h1, {31'h0, slverr});
      apb(1, aspf_pkg::ADDR_BAUD, 32'h0003FFFE);
      peer_u.send(8'h5A, 1'b1);
      apb(0, aspf_pkg::ADDR_CTRL, 0);
      cmp("ready before enable", 32'h0, rdata & 32'h1);
      apb(1, aspf_pkg::ADDR_CTRL, 32'h10);
      fork
         peer_u.send(8'h10, 1'b1);
         begin
            apb(1, aspf_pkg::ADDR_DATA, 32'hC6);
            grab(8, 0);
         end
      join
      cmp("duplex tx", 32'hC6, {24'h0, d});
      for (int i = 1; i < 4; i++) peer_u.send(8'h10 + i[7:0], 1'b1);
      apb(0, aspf_pkg::ADDR_CTRL, 0);
      cmp("ready and overrun", 32'h21, rdata & 32'h21);
      for (int i = 0; i < 4; i++) begin
         apb(0, aspf_pkg::ADDR_DATA, 0);
         cmp("rx fifo", (i < 3) ? 32'h10 + i : 32'h0, rdata);
      end
      peer_u.send(8'h77, 1'b0);
      apb(0, aspf_pkg::ADDR_CTRL, 0);
      cmp("low stop dropped", 32'h100, rdata & 32'h101);
      apb(1, aspf_pkg::ADDR_FMT, 32'h0B);
      peer_u.send(8'h01, 1'b1);
      apb(0, aspf_pkg::ADDR_CTRL, 0);
      cmp("parity error", 32'h80, rdata & 32'h80);
      apb(0, aspf_pkg::ADDR_DATA, 0);
      cmp("parity byte kept", 32'h01, rdata);
      for (int i = 0; i < 8; i++) begin
         f = FMTS[i];
         m = 8'hFF >> (2'h3 - f[1:0]);
         p = ^(DATS[i] & m);
         ex = f[3] ? (f[5] ? ~f[4] : p ^ ~f[4]) : TBXS[i];
         apb(1, aspf_pkg::ADDR_FMT, {24'h0, f});
         apb(1, aspf_pkg::ADDR_CTRL, {28'h0, TBXS[i], 3'h2});
         fork
            grab(5 + f[1:0], f[2] | f[3]);
            begin
               apb(1, aspf_pkg::ADDR_DATA, {24'h0, DATS[i]});
               repeat (2) @(posedge clk);
               apb(0, aspf_pkg::ADDR_CTRL, 0);
               cmp("empty after move", 32'h4, rdata & 32'h4);
               apb(1, aspf_pkg::ADDR_DATA, {24'h0, ~DATS[i]});
               apb(0, aspf_pkg::ADDR_CTRL, 0);
               cmp("holding full", 32'h0, rdata & 32'h4);
            end
         join
         cmp("tx data", {24'h0, DATS[i] & m}, {24'h0, d});
         cmp("tx extra", {31'h0, ex & (f[2] | f[3])}, {31'h0, x});
         cmp("tx stops", (f[6] && f[1:0] != 2'h0) ? 32'h2 : 32'h1, (hi + 2) / 4);
         grab(5 + f[1:0], f[2] | f[3]);
         cmp("tx queued", {24'h0, ~DATS[i] & m}, {24'h0, d});
         apb(0, aspf_pkg::ADDR_CTRL, 0);
         cmp("tx done", 32'h2, rdata & 32'h2);
      end
      tally_and_finish();
   end
endmodule // aspf_top_test
bind aspf_top aspf_assertions chk_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN));
